// ---- logic/cct_pkg.sv ----
// Constants, types and timing for the charge cycle timer control block
package cct_pkg;
	localparam longint CCT_CLK_HZ = 125_000_000; // System clock rate
	localparam longint CCT_REF_HZ = 15_625_000; // Timer reference clock rate
	localparam longint CCT_UA_TIME_S = 900; // Unattended timer, seconds
	localparam longint CCT_WD_TIME_S = 32; // Host watchdog, seconds
	localparam longint CCT_VALID_TIME_MS = 32; // Source validation window, ms
	localparam longint CCT_RDELAY_TIME_MS = 262; // Restart delay after reset bit, ms
	localparam longint CCT_STAT_TIME_US = 125; // Status pulse width, us
	localparam longint CCT_UA_TICKS = CCT_UA_TIME_S * CCT_REF_HZ;
	localparam longint CCT_WD_TICKS = CCT_WD_TIME_S * CCT_REF_HZ;
	localparam longint CCT_VALID_TICKS = (CCT_VALID_TIME_MS * CCT_REF_HZ + 999) / 1000;
	localparam longint CCT_RDELAY_TICKS = (CCT_RDELAY_TIME_MS * CCT_REF_HZ + 999) / 1000;
	localparam longint CCT_STAT_CYC = (CCT_STAT_TIME_US * CCT_CLK_HZ + 999_999) / 1_000_000;
	localparam int CCT_TW = 34; // Timer counter width
	localparam int CCT_SW = 16; // Status pulse counter width
	// Register indices
	localparam logic [2:0] CCT_REG_CTRL = 3'h0;
	localparam logic [2:0] CCT_REG_LIMIT = 3'h1;
	localparam logic [2:0] CCT_REG_VOLT = 3'h2;
	localparam logic [2:0] CCT_REG_CURR = 3'h4;
	localparam logic [2:0] CCT_REG_SPECIAL = 3'h5;
	// Field positions
	localparam int CCT_KICK_BIT = 1;
	localparam int CCT_BUSLIM_LSB = 6;
	localparam int CCT_TE_BIT = 3;
	localparam int CCT_CDIS_BIT = 2;
	localparam int CCT_HZ_BIT = 1;
	localparam int CCT_FLOAT_LSB = 2;
	localparam int CCT_RESET_BIT = 7;
	localparam int CCT_AUX_CHG_LSB = 3;
	localparam int CCT_BUS_CHG_LSB = 4;
	localparam int CCT_TERM_LSB = 0;
	localparam int CCT_LOWCUR_BIT = 5;
	// Fault codes and limits
	localparam logic [2:0] CCT_FLT_NONE = 3'h0;
	localparam logic [2:0] CCT_FLT_OVP = 3'h1;
	localparam logic [2:0] CCT_FLT_POOR = 3'h3;
	localparam logic [2:0] CCT_FLT_TIMER = 3'h6;
	localparam logic [3:0] CCT_AUX_CHG_MAX = 4'hA;
	localparam logic [1:0] CCT_LIM_100 = 2'h0;
	localparam logic [1:0] CCT_LIM_500 = 2'h1;
	// Synchronised pin positions
	localparam int CCT_PIN_W = 9;
	localparam int CCT_P_REF = 0;
	localparam int CCT_P_BUS = 1;
	localparam int CCT_P_AUX = 2;
	localparam int CCT_P_RCH = 3;
	localparam int CCT_P_WEAK = 4;
	localparam int CCT_P_FLOAT = 5;
	localparam int CCT_P_WIN = 6;
	localparam int CCT_P_OVP = 7;
	localparam int CCT_P_OTG = 8;
	// One register set
	typedef struct packed {
		logic [2:0] fault;
		logic charge_disable;
		logic high_impedance;
		logic termination_enable;
		logic [2:0] termination_current_code;
		logic [1:0] bus_input_limit;
		logic [3:0] charge_current_code;
		logic low_current_default;
		logic [5:0] float_voltage;
	} cct_regs_t;
	localparam cct_regs_t CCT_REGS_DEFAULT = '{fault: 3'h0, charge_disable: 1'b0,
		high_impedance: 1'b0, termination_enable: 1'b0, termination_current_code: 3'h0,
		bus_input_limit: 2'h0, charge_current_code: 4'h0, low_current_default: 1'b1,
		float_voltage: 6'h02};
	// Settings applied to the charger
	typedef struct packed {
		logic charge_en;
		logic sel_aux;
		logic load_on;
		logic low_current;
		logic [3:0] charge_current_code;
		logic termination_enable;
		logic [2:0] termination_current_code;
		logic [1:0] bus_input_limit;
		logic [5:0] float_voltage;
	} cct_chg_t;
	// Supervisor states
	typedef enum logic [4:0] {
		CCT_CONFIG = 5'h01,
		CCT_VALIDATE = 5'h02,
		CCT_CHARGE = 5'h04,
		CCT_DELAY = 5'h08,
		CCT_HIZ = 5'h10
	} cct_state_t;
endpackage : cct_pkg

// ---- logic/cct_tick_timer.sv ----
// Reference-tick up counter used for every supervisory timer
`timescale 1ns/1ps
module cct_tick_timer import cct_pkg::*; #(
	parameter int WIDTH = CCT_TW,
	parameter logic [WIDTH-1:0] LIMIT = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tick_in,
	input wire logic start_in,
	input wire logic stop_in,
	output logic running_out,
	output logic expired_out
);
	logic [WIDTH-1:0] cnt; // Ticks seen since start
	logic [WIDTH-1:0] next_cnt;
	logic next_running;
	logic next_expired;

	// Stop wins over start; expiry is a one-cycle pulse
	always_comb begin
		next_cnt = cnt;
		next_running = running_out;
		next_expired = 1'b0;
		if (stop_in) begin
			next_running = 1'b0;
		end else if (start_in) begin
			next_running = 1'b1;
			next_cnt = '0;
		end else if (running_out && tick_in) begin
			if (cnt == LIMIT - 1'b1) begin
				next_running = 1'b0;
				next_expired = 1'b1;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	// Register the timer state
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= '0;
			running_out <= 1'b0;
			expired_out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			running_out <= next_running;
			expired_out <= next_expired;
		end
	end
endmodule : cct_tick_timer

// ---- logic/cct_charge_timer_ctrl.sv ----
// Charge start, safety timers and register sets of the charger supervisor
`timescale 1ns/1ps
module cct_charge_timer_ctrl import cct_pkg::*; #(
	parameter logic [CCT_TW-1:0] UA_TICKS = CCT_TW'(CCT_UA_TICKS),
	parameter logic [CCT_TW-1:0] WD_TICKS = CCT_TW'(CCT_WD_TICKS),
	parameter logic [CCT_TW-1:0] VALID_TICKS = CCT_TW'(CCT_VALID_TICKS),
	parameter logic [CCT_TW-1:0] RDELAY_TICKS = CCT_TW'(CCT_RDELAY_TICKS),
	parameter logic [CCT_SW-1:0] STAT_CYC = CCT_SW'(CCT_STAT_CYC)
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic REF_CLK_IN,
	input wire logic BUS_PRESENT_IN,
	input wire logic AUX_PRESENT_IN,
	input wire logic BAT_BELOW_RECHARGE_IN,
	input wire logic BAT_BELOW_WEAK_IN,
	input wire logic BAT_BELOW_FLOAT_IN,
	input wire logic SRC_IN_WINDOW_IN,
	input wire logic SRC_OVP_IN,
	input wire logic OTG_SELECT_IN,
	input wire logic WR_STB_IN,
	input wire logic WR_AUX_IN,
	input wire logic [2:0] WR_ADDR_IN,
	input wire logic [7:0] WR_DATA_IN,
	output cct_chg_t CHG_CTRL_OUT,
	output cct_regs_t BUS_REGS_OUT,
	output cct_regs_t AUX_REGS_OUT,
	output logic STAT_N_OUT,
	output logic LDO_2V5_EN_OUT,
	output logic HOST_MODE_OUT,
	output logic UNATTENDED_OUT,
	output logic CONFIG_MODE_OUT
);
	logic [CCT_PIN_W-1:0] pin_meta; // First synchroniser stage
	logic [CCT_PIN_W-1:0] pin_sync; // Second synchroniser stage
	logic ref_prev; // Reference level one cycle ago
	cct_state_t state; // Supervisor state
	cct_state_t next_state;
	cct_regs_t regs [2]; // Index 0 bus set, 1 auxiliary set
	cct_regs_t next_regs [2];
	logic [CCT_SW-1:0] stat_cnt; // Remaining status pulse cycles
	logic [CCT_SW-1:0] next_stat_cnt;
	logic prev_bus; // Presence history for edge detection
	logic prev_aux;
	logic prev_rch; // Recharge comparator history
	logic prev_blocked; // Selected set blocked last cycle
	cct_chg_t next_chg;
	logic ref_tick; // One reference clock rising edge
	logic bus_s; // Synchronised pin levels
	logic aux_s;
	logic present;
	logic por; // First source connected
	logic blocked;
	logic unblock;
	logic ua_start;
	logic ua_stop;
	logic ua_run;
	logic ua_exp;
	logic wd_start;
	logic wd_stop;
	logic wd_run;
	logic wd_exp;
	logic v_start;
	logic v_exp;
	logic d_start;
	logic d_exp;
	logic stat_fire;
	logic reset_wr;
	logic kick_wr;

	// Store one host write into a register set
	function automatic cct_regs_t apply_write(input cct_regs_t r, input logic [2:0] a,
		input logic [7:0] d, input logic aux);
		cct_regs_t n;
		n = r;
		case (a)
			CCT_REG_LIMIT: begin
				n.bus_input_limit = d[CCT_BUSLIM_LSB +: 2];
				n.termination_enable = d[CCT_TE_BIT];
				n.charge_disable = d[CCT_CDIS_BIT];
				n.high_impedance = d[CCT_HZ_BIT];
			end
			CCT_REG_VOLT: begin
				n.float_voltage = d[CCT_FLOAT_LSB +: 6];
			end
			CCT_REG_CURR: begin
				n.termination_current_code = d[CCT_TERM_LSB +: 3];
				if (aux) begin
					// Clamp the auxiliary code at ten
					if (d[CCT_AUX_CHG_LSB +: 4] > CCT_AUX_CHG_MAX) begin
						n.charge_current_code = CCT_AUX_CHG_MAX;
					end else begin
						n.charge_current_code = d[CCT_AUX_CHG_LSB +: 4];
					end
				end else begin
					n.charge_current_code = {1'b0, d[CCT_BUS_CHG_LSB +: 3]};
				end
			end
			CCT_REG_SPECIAL: begin
				n.low_current_default = d[CCT_LOWCUR_BIT];
			end
			default: begin
				n = r; // Control byte holds only the kick pulse
			end
		endcase
		return n;
	endfunction : apply_write

	// Two-flop synchronisers for all pin inputs
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pin_meta <= '0;
			pin_sync <= '0;
			ref_prev <= 1'b0;
		end else begin
			pin_meta <= {OTG_SELECT_IN, SRC_OVP_IN, SRC_IN_WINDOW_IN, BAT_BELOW_FLOAT_IN,
				BAT_BELOW_WEAK_IN, BAT_BELOW_RECHARGE_IN, AUX_PRESENT_IN, BUS_PRESENT_IN,
				REF_CLK_IN};
			pin_sync <= pin_meta;
			ref_prev <= pin_sync[CCT_P_REF];
		end
	end

	// Derived events
	assign ref_tick = pin_sync[CCT_P_REF] & ~ref_prev;
	assign bus_s = pin_sync[CCT_P_BUS];
	assign aux_s = pin_sync[CCT_P_AUX];
	assign present = bus_s | aux_s;
	assign por = present & ~(prev_bus | prev_aux);
	assign blocked = regs[aux_s].charge_disable | regs[aux_s].high_impedance;
	assign unblock = prev_blocked & ~blocked & present;
	assign reset_wr = WR_STB_IN && WR_ADDR_IN == CCT_REG_CURR && WR_DATA_IN[CCT_RESET_BIT];
	assign kick_wr = WR_STB_IN && WR_ADDR_IN == CCT_REG_CTRL && WR_DATA_IN[CCT_KICK_BIT];

	// Next state, registers, timer controls and status pulse
	always_comb begin
		next_state = state;
		next_regs = regs;
		ua_start = 1'b0;
		ua_stop = 1'b0;
		wd_start = 1'b0;
		wd_stop = 1'b0;
		stat_fire = (bus_s & ~prev_bus) | (aux_s & ~prev_aux);
		case (state)
			CCT_CONFIG: begin
				if (por && pin_sync[CCT_P_WEAK] && blocked) begin
					next_state = CCT_HIZ;
				end else if (por && !pin_sync[CCT_P_WEAK] && wd_run) begin
					next_state = CCT_VALIDATE;
				end else if (!blocked && present && ((pin_sync[CCT_P_RCH] && !prev_rch)
					|| (por && pin_sync[CCT_P_WEAK]))) begin
					next_state = CCT_VALIDATE;
				end else if (unblock) begin
					next_state = CCT_VALIDATE;
				end
			end
			CCT_VALIDATE: begin
				// Source must hold its window for the whole interval
				if (!present || blocked) begin
					next_state = CCT_CONFIG;
				end else if (!pin_sync[CCT_P_WIN] || pin_sync[CCT_P_OVP]) begin
					next_regs[aux_s].fault = pin_sync[CCT_P_OVP] ? CCT_FLT_OVP
						: CCT_FLT_POOR;
					stat_fire = 1'b1;
					next_state = CCT_CONFIG;
				end else if (v_exp) begin
					next_state = CCT_CHARGE;
				end
			end
			CCT_CHARGE: begin
				if (!present || blocked) begin
					next_state = CCT_CONFIG;
					ua_stop = 1'b1;
				end
			end
			CCT_DELAY: begin
				// Delayed restart after a register reset
				if (d_exp) begin
					next_state = CCT_VALIDATE;
				end
			end
			CCT_HIZ: begin
				next_state = CCT_HIZ; // Left only by watchdog expiry or reset
			end
			default: begin
				next_state = CCT_CONFIG;
			end
		endcase
		// Host writes: any write except a reset-bit write hands over to the watchdog
		if (WR_STB_IN) begin
			next_regs[WR_AUX_IN] = apply_write(regs[WR_AUX_IN], WR_ADDR_IN, WR_DATA_IN,
				WR_AUX_IN);
			ua_stop = 1'b1;
			wd_start = 1'b1;
		end
		if (kick_wr) begin
			wd_start = 1'b1;
		end
		// Reset bit clears only the addressed set
		if (reset_wr) begin
			next_regs[WR_AUX_IN] = CCT_REGS_DEFAULT;
			wd_start = 1'b0;
			wd_stop = 1'b1;
			ua_stop = 1'b1;
			next_state = pin_sync[CCT_P_FLOAT] ? CCT_DELAY : CCT_CONFIG;
		end
		// Watchdog expiry restores defaults in both sets and runs unattended
		if (wd_exp) begin
			for (int i = 0; i < 2; i++) begin
				next_regs[i] = CCT_REGS_DEFAULT;
				next_regs[i].fault = CCT_FLT_TIMER;
			end
			stat_fire = 1'b1;
			if (state == CCT_CHARGE) begin
				ua_start = 1'b1;
			end else if (state != CCT_DELAY && present) begin
				next_state = CCT_VALIDATE;
			end
		end
		// Unattended expiry stops the charger and disables connected sets
		if (ua_exp) begin
			next_state = CCT_CONFIG;
			for (int i = 0; i < 2; i++) begin
				next_regs[i].fault = CCT_FLT_TIMER;
			end
			// Hardware set wins over a host write in the same cycle
			next_regs[0].charge_disable = next_regs[0].charge_disable | bus_s;
			next_regs[1].charge_disable = next_regs[1].charge_disable | aux_s;
			stat_fire = 1'b1;
		end
		// Unattended timer starts with charging unless the host is in control
		if (next_state == CCT_CHARGE && state != CCT_CHARGE && !wd_run && !wd_start) begin
			ua_start = 1'b1;
		end
		v_start = next_state == CCT_VALIDATE && state != CCT_VALIDATE;
		d_start = next_state == CCT_DELAY && state != CCT_DELAY;
		// Status pin low-pulse counter
		if (stat_fire) begin
			next_stat_cnt = STAT_CYC;
		end else if (stat_cnt != '0) begin
			next_stat_cnt = stat_cnt - 1'b1;
		end else begin
			next_stat_cnt = stat_cnt;
		end
	end

	// Charger settings from the set of the selected source; bus input limit from the bus set or the pin
	always_comb begin
		next_chg.charge_en = next_state == CCT_CHARGE;
		next_chg.sel_aux = aux_s;
		next_chg.load_on = next_state == CCT_VALIDATE;
		next_chg.low_current = next_regs[aux_s].low_current_default;
		next_chg.charge_current_code = next_regs[aux_s].low_current_default ? 4'h0
			: next_regs[aux_s].charge_current_code;
		next_chg.termination_enable = next_regs[aux_s].termination_enable;
		next_chg.termination_current_code = next_regs[aux_s].termination_current_code;
		next_chg.float_voltage = next_regs[aux_s].float_voltage;
		// Follow the pin from the first unattended cycle, not one cycle late
		if ((ua_run || ua_start) && !ua_stop && !aux_s) begin
			next_chg.bus_input_limit = pin_sync[CCT_P_OTG] ? CCT_LIM_500
				: CCT_LIM_100;
		end else begin
			next_chg.bus_input_limit = next_regs[0].bus_input_limit;
		end
	end

	// Register all supervisor state and outputs
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state <= CCT_CONFIG;
			regs[0] <= CCT_REGS_DEFAULT;
			regs[1] <= CCT_REGS_DEFAULT;
			stat_cnt <= '0;
			prev_bus <= 1'b0;
			prev_aux <= 1'b0;
			prev_rch <= 1'b0;
			prev_blocked <= 1'b0;
			CHG_CTRL_OUT <= '0;
			STAT_N_OUT <= 1'b1;
			LDO_2V5_EN_OUT <= 1'b0;
			CONFIG_MODE_OUT <= 1'b1;
		end else begin
			state <= next_state;
			regs <= next_regs;
			stat_cnt <= next_stat_cnt;
			prev_bus <= bus_s;
			prev_aux <= aux_s;
			prev_rch <= pin_sync[CCT_P_RCH];
			prev_blocked <= blocked;
			CHG_CTRL_OUT <= next_chg;
			STAT_N_OUT <= next_stat_cnt == '0;
			LDO_2V5_EN_OUT <= aux_s;
			CONFIG_MODE_OUT <= next_state == CCT_CONFIG;
		end
	end

	assign BUS_REGS_OUT = regs[0];
	assign AUX_REGS_OUT = regs[1];
	assign HOST_MODE_OUT = wd_run;
	assign UNATTENDED_OUT = ua_run;

	// Unattended safety timer
	cct_tick_timer #(.WIDTH(CCT_TW), .LIMIT(UA_TICKS)) u_ua (
		.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .tick_in(ref_tick),
		.start_in(ua_start), .stop_in(ua_stop), .running_out(ua_run), .expired_out(ua_exp)
	);
	// Shared host watchdog timer
	cct_tick_timer #(.WIDTH(CCT_TW), .LIMIT(WD_TICKS)) u_wd (
		.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .tick_in(ref_tick),
		.start_in(wd_start), .stop_in(wd_stop), .running_out(wd_run), .expired_out(wd_exp)
	);
	// Source validation window
	cct_tick_timer #(.WIDTH(CCT_TW), .LIMIT(VALID_TICKS)) u_valid (
		.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .tick_in(ref_tick),
		.start_in(v_start), .stop_in(1'b0), .running_out(), .expired_out(v_exp)
	);
	// Restart delay after register reset
	cct_tick_timer #(.WIDTH(CCT_TW), .LIMIT(RDELAY_TICKS)) u_delay (
		.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .tick_in(ref_tick),
		.start_in(d_start), .stop_in(1'b0), .running_out(), .expired_out(d_exp)
	);
endmodule : cct_charge_timer_ctrl

// ---- tb/cct_charge_timer_ctrl_chk.sv ----
// Port-level assertions for the charge timer supervisor
`timescale 1ns/1ps
module cct_charge_timer_ctrl_chk import cct_pkg::*; #(
	parameter logic [CCT_SW-1:0] STAT_CYC = 16'h5
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic BUS_PRESENT_IN,
	input wire logic AUX_PRESENT_IN,
	input wire logic OTG_SELECT_IN,
	input wire logic WR_STB_IN,
	input wire logic WR_AUX_IN,
	input wire logic [2:0] WR_ADDR_IN,
	input wire logic [7:0] WR_DATA_IN,
	input wire cct_chg_t CHG_CTRL_OUT,
	input wire cct_regs_t BUS_REGS_OUT,
	input wire cct_regs_t AUX_REGS_OUT,
	input wire logic STAT_N_OUT,
	input wire logic LDO_2V5_EN_OUT,
	input wire logic HOST_MODE_OUT,
	input wire logic UNATTENDED_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	logic [CCT_SW-1:0] low_cnt; // Cycles the status pin has stayed low
	logic [CCT_SW-1:0] next_low_cnt; // Next pulse width count
	// Restart the width count whenever the pin is high
	always_comb begin
		next_low_cnt = STAT_N_OUT ? '0 : low_cnt + 1'h1;
	end
	// Register the width count
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			low_cnt <= '0;
		end else begin
			low_cnt <= next_low_cnt;
		end
	end
	// Register-reset write and every other write
	sequence s_rst_wr;
		WR_STB_IN && WR_ADDR_IN == CCT_REG_CURR && WR_DATA_IN[CCT_RESET_BIT];
	endsequence
	sequence s_host_wr;
		WR_STB_IN && !(WR_ADDR_IN == CCT_REG_CURR && WR_DATA_IN[CCT_RESET_BIT]);
	endsequence
	write_host_a:
	assert property (s_host_wr |=> HOST_MODE_OUT && !UNATTENDED_OUT)
		else $error("write did not start host watchdog");
	reset_halt_a:
	assert property (s_rst_wr |=> !HOST_MODE_OUT ##1 !CHG_CTRL_OUT.charge_en)
		else $error("reset bit did not halt watchdog and charger");
	reset_scope_a:
	assert property (s_rst_wr |=> ($past(WR_AUX_IN) ? AUX_REGS_OUT : BUS_REGS_OUT) ==
		CCT_REGS_DEFAULT && ($past(WR_AUX_IN) ? $stable(BUS_REGS_OUT) : $stable(AUX_REGS_OUT)))
		else $error("reset bit touched the wrong register set");
	aux_clamp_a:
	assert property (WR_STB_IN && WR_AUX_IN && WR_ADDR_IN == CCT_REG_CURR &&
		!WR_DATA_IN[CCT_RESET_BIT] && WR_DATA_IN[6:3] > CCT_AUX_CHG_MAX
		|=> AUX_REGS_OUT.charge_current_code == CCT_AUX_CHG_MAX)
		else $error("aux charge code not clamped");
	charge_checked_a:
	assert property ($rose(CHG_CTRL_OUT.charge_en) |-> $past(CHG_CTRL_OUT.load_on))
		else $error("charging began without source validation");
	low_cap_a:
	assert property (CHG_CTRL_OUT.low_current |-> CHG_CTRL_OUT.charge_current_code == 4'h0)
		else $error("charge code used while low current set");
	ldo_follow_a:
	assert property ($rose(AUX_PRESENT_IN) |-> ##[1:5] LDO_2V5_EN_OUT)
		else $error("regulator not enabled on aux presence");
	src_notify_a:
	assert property ($rose(BUS_PRESENT_IN) |-> ##[1:8] !STAT_N_OUT)
		else $error("no status pulse on bus presence");
	fault_both_a:
	assert property ($rose(BUS_REGS_OUT.fault == CCT_FLT_TIMER) |->
		AUX_REGS_OUT.fault == CCT_FLT_TIMER ##[0:2] !STAT_N_OUT)
		else $error("timer fault missing in aux set or status");
	stat_width_a:
	assert property ($rose(STAT_N_OUT) |-> low_cnt >= STAT_CYC)
		else $error("status pulse too short");
	pin_limit_a:
	assert property (UNATTENDED_OUT && $past(UNATTENDED_OUT, 2) && CHG_CTRL_OUT.charge_en &&
		!CHG_CTRL_OUT.sel_aux && OTG_SELECT_IN == $past(OTG_SELECT_IN, 6) |->
		CHG_CTRL_OUT.bus_input_limit == (OTG_SELECT_IN ? CCT_LIM_500 : CCT_LIM_100))
		else $error("unattended bus limit ignores select pin");
endmodule : cct_charge_timer_ctrl_chk
bind cct_charge_timer_ctrl cct_charge_timer_ctrl_chk #(.STAT_CYC(STAT_CYC)) u_chk (
	.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .BUS_PRESENT_IN(BUS_PRESENT_IN),
	.AUX_PRESENT_IN(AUX_PRESENT_IN), .OTG_SELECT_IN(OTG_SELECT_IN), .WR_STB_IN(WR_STB_IN),
	.WR_AUX_IN(WR_AUX_IN), .WR_ADDR_IN(WR_ADDR_IN), .WR_DATA_IN(WR_DATA_IN),
	.CHG_CTRL_OUT(CHG_CTRL_OUT), .BUS_REGS_OUT(BUS_REGS_OUT), .AUX_REGS_OUT(AUX_REGS_OUT),
	.STAT_N_OUT(STAT_N_OUT), .LDO_2V5_EN_OUT(LDO_2V5_EN_OUT), .HOST_MODE_OUT(HOST_MODE_OUT),
	.UNATTENDED_OUT(UNATTENDED_OUT));

// ---- tb/cct_host_model.sv ----
// Host processor model issuing decoded register writes and watchdog kicks
`timescale 1ns/1ps
module cct_host_model import cct_pkg::*; (
	input wire logic clk_in,
	output logic wr_stb_out,
	output logic wr_aux_out,
	output logic [2:0] wr_addr_out,
	output logic [7:0] wr_data_out
);
	// Idle lines carry no meaningful value
	initial begin
		wr_stb_out = 1'h0;
		wr_aux_out = 1'h0;
		wr_addr_out = 3'h7;
		wr_data_out = 8'hA5;
	end
	// One byte per strobe, strobe high for one cycle
	task automatic write_reg(input logic aux, input logic [2:0] addr, input logic [7:0] data);
		@(posedge clk_in);
		wr_stb_out <= 1'h1;
		wr_aux_out <= aux;
		wr_addr_out <= addr;
		wr_data_out <= data;
		@(posedge clk_in);
		wr_stb_out <= 1'h0;
		wr_addr_out <= ~addr; // Released lines never show the stale byte
		wr_data_out <= ~data;
	endtask : write_reg
	// Keep the shared watchdog alive through either address
	task automatic kick(input logic aux);
		write_reg(aux, CCT_REG_CTRL, 8'h02);
	endtask : kick
endmodule : cct_host_model

// ---- tb/test_cct_charge_timer_ctrl.sv ----
// Self-checking bench for the charge timer supervisor
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %0h seen %0h", n, e, g); end end
`define WAITC(c, n) begin @(negedge clk); for (int w = 0; w < (n) && !(c); w++) \
	@(negedge clk); end
module test_cct_charge_timer_ctrl import cct_pkg::*;;
	logic clk, rst_n, ref_clk, bus_present, aux_present, bat_rch, bat_weak, bat_float;
	logic src_win, src_ovp, otg_select, wr_stb, wr_aux, stat_n, ldo_en;
	logic host_mode, unattended, config_mode;
	logic [2:0] wr_addr;
	logic [7:0] wr_data;
	cct_chg_t chg;
	cct_regs_t bus_regs, aux_regs;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	// Short timers: 20, 10, 4, 6 reference ticks of 8 clocks; 5-cycle status pulse
	cct_charge_timer_ctrl #(.UA_TICKS(34'h14), .WD_TICKS(34'hA), .VALID_TICKS(34'h4),
		.RDELAY_TICKS(34'h6), .STAT_CYC(16'h5)) DUT (
		.CLK_IN(clk), .RST_N_IN(rst_n), .REF_CLK_IN(ref_clk), .BUS_PRESENT_IN(bus_present),
		.AUX_PRESENT_IN(aux_present), .BAT_BELOW_RECHARGE_IN(bat_rch),
		.BAT_BELOW_WEAK_IN(bat_weak), .BAT_BELOW_FLOAT_IN(bat_float), .SRC_IN_WINDOW_IN(src_win),
		.SRC_OVP_IN(src_ovp), .OTG_SELECT_IN(otg_select), .WR_STB_IN(wr_stb), .WR_AUX_IN(wr_aux),
		.WR_ADDR_IN(wr_addr), .WR_DATA_IN(wr_data), .CHG_CTRL_OUT(chg), .BUS_REGS_OUT(bus_regs),
		.AUX_REGS_OUT(aux_regs), .STAT_N_OUT(stat_n), .LDO_2V5_EN_OUT(ldo_en),
		.HOST_MODE_OUT(host_mode), .UNATTENDED_OUT(unattended), .CONFIG_MODE_OUT(config_mode));
	cct_host_model host (.clk_in(clk), .wr_stb_out(wr_stb), .wr_aux_out(wr_aux),
		.wr_addr_out(wr_addr), .wr_data_out(wr_data));
	// System clock, 8 ns
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// Timer reference, 64 ns, unrelated in phase
	initial begin
		ref_clk = 1'h0;
		#3.3;
		forever #32 ref_clk = ~ref_clk;
	end
	// Verdict and end of run
	task automatic finish_test;
		if (mismatches == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	// Weak battery power-on charges unattended until the safety timer runs out
	task automatic t_boot;
		@(posedge clk);
		bus_present <= 1'h1;
		`WAITC(!stat_n, 10)
		`CHK("plug notify", 1'h0, stat_n)
		`WAITC(chg.load_on, 40)
		`CHK("load first", 2'h2, {chg.load_on, chg.charge_en})
		`WAITC(chg.charge_en, 60)
		`CHK("charge start", 2'h3, {chg.charge_en, unattended})
		`CHK("select low limit", CCT_LIM_100, chg.bus_input_limit)
		`CHK("default charge", 7'h42, {chg.low_current, chg.float_voltage})
		`WAITC(!chg.charge_en, 200)
		`CHK("timer fault", {CCT_FLT_TIMER, CCT_FLT_TIMER},
			{bus_regs.fault, aux_regs.fault})
		`CHK("disable set", 2'h2, {bus_regs.charge_disable, aux_regs.charge_disable})
		`CHK("config", 1'h1, config_mode)
	endtask : t_boot
	// Host programs, unblocks, kicks, then lets the watchdog expire
	task automatic t_host;
		cct_regs_t exp;
		exp = CCT_REGS_DEFAULT;
		exp.fault = CCT_FLT_TIMER;
		host.write_reg(1'h0, CCT_REG_LIMIT, 8'h48);
		`WAITC(1'h0, 0)
		`CHK("host mode", 2'h2, {host_mode, unattended})
		host.write_reg(1'h0, CCT_REG_SPECIAL, 8'h00);
		host.write_reg(1'h0, CCT_REG_CURR, 8'h53);
		host.write_reg(1'h1, CCT_REG_CURR, 8'h78);
		`WAITC(1'h0, 0)
		`CHK("aux clamp", CCT_AUX_CHG_MAX, aux_regs.charge_current_code)
		`WAITC(chg.charge_en, 60)
		`CHK("unblock charge", 1'h1, chg.charge_en)
		`CHK("applied set", 7'h2D, {chg.low_current, chg.termination_enable,
			chg.termination_current_code, chg.bus_input_limit})
		repeat (3) begin
			repeat (40) @(posedge clk);
			host.kick(1'h1);
		end
		`WAITC(1'h0, 0)
		`CHK("kept by kicks", 3'h5, {host_mode, bus_regs.bus_input_limit})
		`WAITC(!host_mode, 120)
		`WAITC(1'h0, 0)
		`CHK("bus defaults", exp, bus_regs)
		`CHK("aux defaults", exp, aux_regs)
		`WAITC(1'h0, 2)
		`CHK("resume unattended", 2'h3, {unattended, chg.charge_en})
	endtask : t_host
	// Reset bit clears only the bus set and restarts after the delay
	task automatic t_reset;
		int n;
		@(posedge clk);
		otg_select <= 1'h1;
		host.write_reg(1'h1, CCT_REG_VOLT, 8'h10);
		host.write_reg(1'h0, CCT_REG_CURR, 8'h80);
		`WAITC(1'h0, 1)
		`CHK("reset halt", 2'h0, {host_mode, chg.charge_en})
		`CHK("bus reset", CCT_REGS_DEFAULT, bus_regs)
		`CHK("aux kept", 6'h04, aux_regs.float_voltage)
		n = 0;
		while (!chg.load_on && n < 100) begin
			@(negedge clk);
			n++;
		end
		`CHK("restart delay", 1'h1, (n >= 40 && n < 100))
		`WAITC(chg.charge_en, 60)
		`CHK("select high limit", {1'h1, CCT_LIM_500}, {unattended, chg.bus_input_limit})
	endtask : t_reset
	// Validation against over-voltage then a poor source
	task automatic t_fail;
		for (int i = 0; i < 2; i++) begin
			host.write_reg(1'h0, CCT_REG_LIMIT, 8'h02);
			src_ovp <= (i == 0);
			src_win <= 1'h0;
			repeat (6) @(posedge clk);
			host.write_reg(1'h0, CCT_REG_LIMIT, 8'h00);
			`WAITC(bus_regs.fault == (i == 0 ? CCT_FLT_OVP : CCT_FLT_POOR), 20)
			`CHK("source fault", (i == 0 ? CCT_FLT_OVP : CCT_FLT_POOR), bus_regs.fault)
			`WAITC(!stat_n, 8)
			`CHK("fault pulse", 1'h0, stat_n)
		end
		@(posedge clk);
		src_ovp <= 1'h0;
		src_win <= 1'h1;
	endtask : t_fail
	// Auxiliary plug-in enables the regulator and notifies
	task automatic t_aux;
		@(posedge clk);
		aux_present <= 1'h1;
		`WAITC(ldo_en, 8)
		`CHK("regulator on", 1'h1, ldo_en)
		`WAITC(!stat_n, 8)
		`CHK("aux notify", 1'h0, stat_n)
	endtask : t_aux
	// Replug above weak under host control, reset above float, then recharge
	task automatic t_replug;
		@(posedge clk);
		{bus_present, aux_present, bat_weak, bat_float} <= 4'h0;
		repeat (4) @(posedge clk);
		host.write_reg(1'h0, CCT_REG_VOLT, 8'h20);
		bus_present <= 1'h1;
		`WAITC(chg.charge_en, 60)
		`CHK("hosted power-on", 3'h6, {chg.charge_en, host_mode, unattended})
		host.write_reg(1'h0, CCT_REG_CURR, 8'h80);
		`WAITC(1'h0, 60)
		`CHK("no delayed restart", 2'h2, {config_mode, chg.load_on})
		@(posedge clk);
		bat_rch <= 1'h1;
		`WAITC(chg.charge_en, 60)
		`CHK("recharge start", 3'h7, {chg.charge_en, unattended, chg.low_current})
	endtask : t_replug
	// Reset, then the scenarios in order
	initial begin
		rst_n = 1'h0;
		bus_present = 1'h0;
		aux_present = 1'h0;
		bat_rch = 1'h0;
		bat_weak = 1'h1;
		bat_float = 1'h1;
		src_win = 1'h1;
		src_ovp = 1'h0;
		otg_select = 1'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		t_boot();
		t_host();
		t_reset();
		t_fail();
		t_aux();
		t_replug();
		finish_test();
	end
endmodule : test_cct_charge_timer_ctrl
